// ---- hdl/eirq_cfg.svh ----
// Offsets, field positions, reset values and widths of the interrupt status block.
// Assumes it is included by bare name from the package and the top design file.
`ifndef EIRQ_CFG_SVH
`define EIRQ_CFG_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define EIRQ_AW            8
`define EIRQ_DW            16

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EIRQ_OFS_ENABLE    8'h00
`define EIRQ_OFS_STATUS    8'h02
`define EIRQ_OFS_LEVEL     8'h10

// ----------------------------------------
// Flag positions
// ----------------------------------------
`define EIRQ_BIT_LINK      15
`define EIRQ_BIT_TX_DONE   14
`define EIRQ_BIT_RX_DONE   13
`define EIRQ_BIT_TX_UNDER  12
`define EIRQ_BIT_RX_OVER   11
`define EIRQ_BIT_RX_EARLY  10
`define EIRQ_BIT_TX_HALT   9
`define EIRQ_BIT_RX_HALT   8
`define EIRQ_BIT_RX_BAD    7
`define EIRQ_FLAG_LO       7
`define EIRQ_NFLAGS        9

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define EIRQ_STATUS_RST    16'h0300
`define EIRQ_ENABLE_RST    16'h0000
`define EIRQ_FLAG_MASK     16'hff80

`endif

// ---- hdl/eirq_pkg.sv ----
// Types shared by the interrupt status block and its users.
// Assumes eirq_cfg.svh is on the include path.
`include "eirq_cfg.svh"

package eirq_pkg;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic [`EIRQ_AW-1:0] addr;
    logic [`EIRQ_DW-1:0] wdata;
    logic                wr;
    logic                rd;
  } eirq_req_t;

  // ----------------------------------------
  // Event levels, first member is the top flag
  // ----------------------------------------
  typedef struct packed {
    logic link_up;
    logic transmit_done;
    logic receive_done;
    logic transmit_underrun;
    logic receive_overrun;
    logic early_receive;
    logic transmit_halted;
    logic receive_halted;
    logic receive_bad_frame;
  } eirq_evt_t;

  typedef enum logic [1:0] {
    EIRQ_SEL_NONE   = 2'b00,
    EIRQ_SEL_ENABLE = 2'b01,
    EIRQ_SEL_STATUS = 2'b10,
    EIRQ_SEL_LEVEL  = 2'b11
  } eirq_sel_t;

endpackage

// ---- hdl/eirq_sync.sv ----
// Three-stage synchroniser for a level from another domain, with change pulse.
// Assumes mclk domain reset already synchronised; ce freezes every stage.
`timescale 1ns/1ns

module eirq_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level,
  output logic      change
);

  logic meta_q;
  logic mid_q;
  logic last_q;
  logic primed_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      mid_q  <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= async_in;
      mid_q  <= meta_q;
      last_q <= mid_q;
    end
  end

  // First agreement after reset only primes, but the zeroed stages agree at once, so a link already up still gives a change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level    <= 1'b0;
      change   <= 1'b0;
      primed_q <= 1'b0;
    end else if (ce) begin
      change <= 1'b0;
      if (mid_q == last_q) begin
        primed_q <= 1'b1;
        level    <= mid_q;
        if (primed_q && (mid_q != level)) begin
          change <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- hdl/eirq_flag.sv ----
// One sticky status flag: set on an event's rising edge, cleared by write-one.
// Assumes event level and clear pulse come from logic on mclk.
`timescale 1ns/1ns

module eirq_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic event_level,
  input  wire logic clr,
  output logic      flag
);

  logic prev_q;
  logic set;

  assign set = event_level & ~prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= event_level;
    end
  end

  // Set beats a clear in the same cycle, so no event is lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RST_VAL;
    end else if (ce) begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule

// ---- hdl/eirq_top.sv ----
// Interrupt status and enable registers of a single-port Ethernet controller.
// Assumes event levels come from logic on mclk, except link_up which is a pin level.
// Registers are reached over a plain port with read data one cycle after the strobe.
//
// What this block does
// - The interrupt output is high while any flag is set together with its enable bit.
// - Reading the status register returns the flags and leaves them all unchanged.
// - Writing one to a status bit clears that flag, writing zero leaves it alone.
// - The link change flag at bit 15 sets on every link up or link down transition.
// - The transmit done flag at bit 14 sets when a frame went out and the queue takes more.
// - The receive done flag at bit 13 sets when a whole frame is ready for the host.
// - The transmit underrun flag at bit 12 sets on every transmit underrun.
// - The receive overrun flag at bit 11 sets on every receive overrun.
// - The early receive flag at bit 10 sets on every early receive condition.
// - The transmit halted flag at bit 9 sets when transmit stops and resets to one.
// - The receive halted flag at bit 8 sets when receive stops and resets to one.
// - The receive bad frame flag at bit 7 sets on every received frame in error.
// - The enable register at offset 0x00 holds one read-write bit per flag, reset to zero.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns

`include "eirq_cfg.svh"

module eirq_top #(
  parameter int NFLAGS = `EIRQ_NFLAGS
) (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire eirq_pkg::eirq_req_t req,
  input  wire eirq_pkg::eirq_evt_t evt,
  output logic [`EIRQ_DW-1:0]      rdata,
  output logic                     irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Reset synchroniser runs free of ce so reset always releases
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Link state crossing
  // ----------------------------------------
  logic link_level;
  logic link_change;

  eirq_sync u_link_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (evt.link_up),
    .level    (link_level),
    .change   (link_change)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  eirq_pkg::eirq_sel_t sel;

  always_comb begin
    unique case (req.addr)
      `EIRQ_OFS_ENABLE: begin
        sel = eirq_pkg::EIRQ_SEL_ENABLE;
      end
      `EIRQ_OFS_STATUS: begin
        sel = eirq_pkg::EIRQ_SEL_STATUS;
      end
      `EIRQ_OFS_LEVEL: begin
        sel = eirq_pkg::EIRQ_SEL_LEVEL;
      end
      default: begin
        sel = eirq_pkg::EIRQ_SEL_NONE;
      end
    endcase
  end

  logic wr_enable;
  logic wr_status;

  assign wr_enable = req.wr & (sel == eirq_pkg::EIRQ_SEL_ENABLE);
  assign wr_status = req.wr & (sel == eirq_pkg::EIRQ_SEL_STATUS);

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  logic [`EIRQ_DW-1:0] enable_q;

  // Reserved low bits are never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `EIRQ_ENABLE_RST;
    end else if (ce && wr_enable) begin
      enable_q <= req.wdata & `EIRQ_FLAG_MASK;
    end
  end

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  logic [NFLAGS-1:0] src;

  // Link change is fed as a one-cycle pulse, so its rising edge is the pulse itself
  always_comb begin
    src = '0;
    src[`EIRQ_BIT_LINK     - `EIRQ_FLAG_LO] = link_change;
    src[`EIRQ_BIT_TX_DONE  - `EIRQ_FLAG_LO] = evt.transmit_done;
    src[`EIRQ_BIT_RX_DONE  - `EIRQ_FLAG_LO] = evt.receive_done;
    src[`EIRQ_BIT_TX_UNDER - `EIRQ_FLAG_LO] = evt.transmit_underrun;
    src[`EIRQ_BIT_RX_OVER  - `EIRQ_FLAG_LO] = evt.receive_overrun;
    src[`EIRQ_BIT_RX_EARLY - `EIRQ_FLAG_LO] = evt.early_receive;
    src[`EIRQ_BIT_TX_HALT  - `EIRQ_FLAG_LO] = evt.transmit_halted;
    src[`EIRQ_BIT_RX_HALT  - `EIRQ_FLAG_LO] = evt.receive_halted;
    src[`EIRQ_BIT_RX_BAD   - `EIRQ_FLAG_LO] = evt.receive_bad_frame;
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  localparam logic [`EIRQ_DW-1:0] STATUS_RST = `EIRQ_STATUS_RST;

  logic [NFLAGS-1:0] flags;
  logic [NFLAGS-1:0] clr;

  // A write of one clears, a read never touches a flag
  assign clr = wr_status ? req.wdata[`EIRQ_FLAG_LO +: NFLAGS] : '0;

  for (genvar i = 0; i < NFLAGS; i++) begin : g_flag
    eirq_flag #(
      .RST_VAL (STATUS_RST[`EIRQ_FLAG_LO + i])
    ) u_flag (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .ce          (ce),
      .event_level (src[i]),
      .clr         (clr[i]),
      .flag        (flags[i])
    );
  end

  logic [`EIRQ_DW-1:0] status;

  // Bits 6..0 are constant zero
  assign status = {flags, {`EIRQ_FLAG_LO{1'b0}}};

  // ----------------------------------------
  // Live event levels, debug view
  // ----------------------------------------
  logic [`EIRQ_DW-1:0] level_view;

  always_comb begin
    level_view = {src, {`EIRQ_FLAG_LO{1'b0}}};
    level_view[`EIRQ_BIT_LINK] = link_level;
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [`EIRQ_DW-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      unique case (sel)
        eirq_pkg::EIRQ_SEL_ENABLE: begin
          rdata_d = enable_q;
        end
        eirq_pkg::EIRQ_SEL_STATUS: begin
          rdata_d = status;
        end
        eirq_pkg::EIRQ_SEL_LEVEL: begin
          rdata_d = level_view;
        end
        eirq_pkg::EIRQ_SEL_NONE: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= rdata_d;
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  logic irq_d;

  // Registered, so it follows the flags and enables one cycle late
  assign irq_d = |(status & enable_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_d;
    end
  end

endmodule

// ---- sim/eirq_src.sv ----
// Event sources behind the status block: levels register one edge late.
// Assumes the bench sets the wanted levels just after a rising edge.
`timescale 1ns/1ns

module eirq_src (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire eirq_pkg::eirq_evt_t want,
  output eirq_pkg::eirq_evt_t      evt
);
  // ----
  // Registered levels, so edges always land on mclk
  // ----
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      evt <= 9'h000;
    else
      evt <= want;
  end
endmodule

// ---- sim/eirq_top_properties.sv ----
// Checker on the ports of the interrupt status block.
// Assumes bus writes count only with ce high, and mirrors the enable register from them.
`timescale 1ns/1ns
`include "eirq_cfg.svh"

module eirq_chk #(
  parameter int NFLAGS = `EIRQ_NFLAGS
) (
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                ce,
  input wire eirq_pkg::eirq_req_t req,
  input wire eirq_pkg::eirq_evt_t evt,
  input wire logic [`EIRQ_DW-1:0] rdata,
  input wire logic                irq
);
  // ----
  // Shadow enable and event edges
  // ----
  logic [15:0] en_q;
  logic [8:0]  evt_q;
  logic [7:0]  rise;
  logic        rd_st;
  assign rise  = evt[7:0] & ~evt_q[7:0];
  assign rd_st = ce && req.rd && req.addr == `EIRQ_OFS_STATUS;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      en_q <= 16'h0000;
    else if (ce && req.wr && req.addr == `EIRQ_OFS_ENABLE)
      en_q <= req.wdata & `EIRQ_FLAG_MASK;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      evt_q <= 9'h000;
    else if (ce)
      evt_q <= evt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_low_bits: assert property (rdata[6:0] == 7'h00)
    else $error("low status bits not zero");
  a_irq_needs_en: assert property (irq |-> $past(en_q) != 16'h0000)
    else $error("irq with nothing enabled");
  a_event_irq: assert property (($past(rise) & en_q[14:7]) != 8'h00 |=> irq)
    else $error("enabled event gave no irq");
  a_flag_seen: assert property ((rise != 8'h00) ##1 rd_st |=>
    (rdata[14:7] & $past(rise, 2)) == $past(rise, 2))
    else $error("event flag missing on read");
  a_clear_status: assert property ((ce && req.wr && req.addr == `EIRQ_OFS_STATUS) ##2 rd_st
    |=> (rdata[14:7] & $past(req.wdata[14:7], 3) & ~$past(rise, 3) & ~$past(rise, 2)) == 8'h00)
    else $error("cleared flag still set");
  a_read_keeps: assert property (rd_st ##1 rd_st |=>
    (rdata[15:7] & $past(rdata[15:7])) == $past(rdata[15:7]))
    else $error("read cleared a flag");
  a_enable_read: assert property (ce && req.rd && req.addr == `EIRQ_OFS_ENABLE |=> rdata == en_q)
    else $error("enable readback wrong");
  a_clear_drops: assert property (ce && req.wr && req.addr == `EIRQ_OFS_STATUS && !en_q[15]
    && rise == 8'h00 && (req.wdata[14:7] | ~en_q[14:7]) == 8'hff |-> ##2 !irq)
    else $error("irq stayed after clear");
endmodule

bind eirq_top eirq_chk #(.NFLAGS(NFLAGS)) eirq_chk_i (.mclk(mclk), .nrst(nrst), .ce(ce),
  .req(req), .evt(evt), .rdata(rdata), .irq(irq));

// ---- sim/tb_ethernet_ctrl_irq_status.sv ----
// Testbench of the interrupt status block: bus tasks and event sequences.
// Assumes the event source model and the bound checker are compiled too.
`timescale 1ns/1ns
`include "eirq_cfg.svh"

module tb_ethernet_ctrl_irq_status;
  logic                mclk        = 1'b0;
  logic                nrst        = 1'b0;
  logic                ce          = 1'b1;
  eirq_pkg::eirq_req_t req         = 26'h0000000;
  eirq_pkg::eirq_evt_t want        = 9'h000;
  eirq_pkg::eirq_evt_t evt;
  logic [15:0]         rdata;
  logic                irq;
  int                  mismatches  = 0;
  int                  checks_done = 0;

  always #4 mclk = ~mclk;
  eirq_src eirq_src_i (.mclk(mclk), .nrst(nrst), .want(want), .evt(evt));
  eirq_top eirq_top_i (.mclk(mclk), .nrst(nrst), .ce(ce), .req(req), .evt(evt),
    .rdata(rdata), .irq(irq));

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= v;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`EIRQ_OFS_STATUS, 16'h0300);
    rd(`EIRQ_OFS_ENABLE, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(`EIRQ_OFS_ENABLE, 16'hffff);
    rd(`EIRQ_OFS_ENABLE, 16'hff80);
    chk({15'h0000, irq}, 16'h0001);
    // Two reads back to back, second must still show both flags
    @(posedge mclk);
    req.rd <= 1'b1;
    req.addr <= `EIRQ_OFS_STATUS;
    repeat (2) @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, 16'h0300);
    wr(`EIRQ_OFS_STATUS, 16'h017f);
    rd(`EIRQ_OFS_STATUS, 16'h0200);
    wr(`EIRQ_OFS_STATUS, 16'h0200);
    repeat (2) @(negedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      @(posedge mclk);
      want <= 9'h001 << j;
      @(posedge mclk);
      want <= 9'h000;
      rd(`EIRQ_OFS_STATUS, 16'h0080 << j);
      chk({15'h0000, irq}, 16'h0001);
      wr(`EIRQ_OFS_STATUS, 16'hff80);
    end
    wr(`EIRQ_OFS_ENABLE, 16'h2000);
    rd(`EIRQ_OFS_ENABLE, 16'h2000);
    // Frozen clock enable must drop a write
    @(posedge mclk);
    ce <= 1'b0;
    wr(`EIRQ_OFS_ENABLE, 16'h0000);
    ce <= 1'b1;
    rd(`EIRQ_OFS_ENABLE, 16'h2000);
    @(posedge mclk);
    want <= 9'h080;
    // Late enough that a wrongly enabled flag would already show on irq
    repeat (4) @(negedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    rd(`EIRQ_OFS_STATUS, 16'h4000);
    rd(`EIRQ_OFS_LEVEL, 16'h4000);
    wr(`EIRQ_OFS_STATUS, 16'h4000);
    // Event edge lands on the clearing write, level then held
    @(posedge mclk);
    want <= 9'h040;
    wr(`EIRQ_OFS_STATUS, 16'h2000);
    rd(`EIRQ_OFS_STATUS, 16'h2000);
    chk({15'h0000, irq}, 16'h0001);
    wr(`EIRQ_OFS_STATUS, 16'h2000);
    rd(`EIRQ_OFS_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge mclk);
    want <= 9'h000;
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      want.link_up <= ~want.link_up;
      repeat (10) @(posedge mclk);
      rd(`EIRQ_OFS_STATUS, 16'h8000);
      wr(`EIRQ_OFS_STATUS, 16'h8000);
    end
    // Second reset in mid-run restores the power-up values
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`EIRQ_OFS_STATUS, 16'h0300);
    rd(`EIRQ_OFS_ENABLE, 16'h0000);
    report_and_stop();
  end

  // Whole run is under two hundred cycles
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
